// [dv/csc_board_model.sv]
// Board-side model of the channel B loss indicator trace.
`timescale 1ns/10ps
`default_nettype none
module csc_board_model (
    // Clock.
    input wire logic aclk,
    // Indicator driver of the device.
    input wire logic chb_signal_loss_flag,
    input wire logic chb_signal_loss_oe_n,
    // Level seen on the trace.
    output logic pin_level
);
    logic last;
    // The trace has no pull, so a floating pin shows the inverse of the last driven level.
    always_ff @(posedge aclk) begin
        if (!chb_signal_loss_oe_n) last <= chb_signal_loss_flag;
    end
    assign pin_level = chb_signal_loss_oe_n ? ~last : chb_signal_loss_flag;
endmodule // csc_board_model
`default_nettype wire

// [dv/csc_chb_pins_checker.sv]
// Port assertions for the channel B pin logic.
`timescale 1ns/10ps
`default_nettype none
module csc_chb_pins_checker
    import csc_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Watched ports.
    input wire logic chb_rotation_jog,
    input wire logic chb_powerdown_n,
    input wire logic [3:0] port_strap,
    input wire logic [4:0] mgmt_port_addr,
    input wire logic chb_signal_loss_flag,
    input wire logic chb_signal_loss_oe_n,
    input wire logic [1:0] chb_lane_rotation,
    input wire logic chb_powered_down,
    input wire logic mgmt_selected
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire hit = (mgmt_port_addr == {port_strap, CSC_PA_CHB});
    ////////////////////////////////////////
    property p_rst; $rose(aresetn) |-> !chb_signal_loss_flag && !chb_signal_loss_oe_n; endproperty
    a_rst: assert property (p_rst) else $error("indicator not low in reset");
    property p_pd; $fell(chb_powerdown_n) |-> ##[3:8] chb_powered_down; endproperty
    a_pd: assert property (p_pd) else $error("pin power-down ignored");
    property p_float; chb_powered_down |-> ##[0:2] chb_signal_loss_oe_n; endproperty
    a_float: assert property (p_float) else $error("indicator driven in power-down");
    property p_wake; $fell(chb_powered_down) |-> ##[0:2] !chb_signal_loss_oe_n; endproperty
    a_wake: assert property (p_wake) else $error("indicator not driven after wake");
    // A step other than one would skip a lane of the rotation.
    property p_step; $changed(chb_lane_rotation) |-> chb_lane_rotation == $past(chb_lane_rotation) + 2'h1; endproperty
    a_step: assert property (p_step) else $error("rotation step not one");
    property p_jog; $changed(chb_rotation_jog) && !chb_powered_down |-> ##[3:7] $changed(chb_lane_rotation); endproperty
    a_jog: assert property (p_jog) else $error("jog edge without rotation");
    property p_hit; hit |=> mgmt_selected; endproperty
    a_hit: assert property (p_hit) else $error("own port address not answered");
    property p_miss; !hit |=> !mgmt_selected; endproperty
    a_miss: assert property (p_miss) else $error("foreign port address answered");
    cover property (chb_powered_down ##1 !chb_powered_down);
    cover property ($changed(chb_lane_rotation));
    cover property (mgmt_selected);
endmodule // csc_chb_pins_checker
bind csc_chb_pins csc_chb_pins_checker csc_chb_pins_checker_inst (.*);
`default_nettype wire

// [dv/csc_chb_pins_tb.sv]
// Self-checking bench for the channel B pin logic.
`timescale 1ns/10ps
`default_nettype none
module csc_chb_pins_tb
    import csc_pkg::*;
;
    // Stimulus and observed signals.
    logic aclk, chb_signal_loss_flag, chb_signal_loss_oe_n, chb_ref_use_one, chb_powered_down;
    logic aresetn = 0, chb_rotation_jog = 0, chb_powerdown_n = 1, chb_refclk_select = 0;
    logic chb_swing_low = 0, chb_swing_high = 1, chb_datapath_reset, mgmt_selected, pin_level;
    logic [3:0] port_strap = 4'ha, s_axi_wstrb = 4'hf;
    logic [4:0] mgmt_port_addr = 5'h00;
    logic [1:0] chb_lane_rotation, s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int n_mismatch = 0, checked = 0, n_pulse = 0;
    csc_chb_pins csc_chb_pins_inst (.*);
    csc_board_model csc_board_model_inst (.*);
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    // The whole sequence needs a few hundred cycles.
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    always @(posedge aclk) if (chb_datapath_reset === 1'b1) n_pulse++;
    ////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1;
                s_axi_bready <= 1'b0;
                cmp("bresp", 32'(r), 32'(s_axi_bresp));
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                done = 1;
                s_axi_rready <= 1'b0;
                cmp("rdata", d, s_axi_rdata);
                cmp("rresp", 32'(r), 32'(s_axi_rresp));
            end
        end
    endtask
    ////////////////////////////////////////
    initial begin
        cyc(5);
        cmp("pin", 32'h0, 32'(pin_level));
        aresetn <= 1'b1;
        rd(CSC_CTRL_ADDR, CSC_CTRL_RESET, CSC_RESP_OKAY);
        rd(CSC_PORT_ADDR, {27'h0, port_strap, CSC_PA_CHB}, CSC_RESP_OKAY);
        rd(8'h10, CSC_READ_FILL, CSC_RESP_SLVERR);
        wr(8'h10, 32'hff, CSC_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(CSC_CTRL_ADDR, {31'h0, ~i[1]}, CSC_RESP_OKAY);
            chb_swing_low <= ~i[0];
            chb_swing_high <= i[0];
            cyc(8);
            cmp("los", {31'h0, ~i[1] & ~i[0]}, 32'(pin_level));
        end
        wr(CSC_CTRL_ADDR, 32'h1, CSC_RESP_OKAY);
        chb_swing_low <= 1'b1;
        chb_swing_high <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            chb_rotation_jog <= ~chb_rotation_jog;
            cyc(10);
        end
        cmp("rot", 32'h1, 32'(chb_lane_rotation));
        rd(CSC_ROT_ADDR, 32'h1, CSC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(CSC_CTRL_ADDR, 32'h1 | (32'(i) << 4), CSC_RESP_OKAY);
            cyc(3);
            cmp("obs", {31'h0, i < 2}, 32'(pin_level));
        end
        for (int i = 0; i < 8; i++) begin
            wr(CSC_CTRL_ADDR, 32'h1 | ((32'(i) & 32'h6) << 1), CSC_RESP_OKAY);
            chb_refclk_select <= i[0];
            cyc(8);
            cmp("ref", {31'h0, i[1] & i[2] & ~i[0]}, 32'(chb_ref_use_one));
        end
        wr(CSC_CTRL_ADDR, 32'h1, CSC_RESP_OKAY);
        chb_powerdown_n <= 1'b0;
        cyc(8);
        cmp("oe_n", 32'h1, 32'(chb_signal_loss_oe_n));
        cmp("pd", 32'h1, 32'(chb_powered_down));
        rd(CSC_STATUS_ADDR, 32'h7, CSC_RESP_OKAY);
        chb_rotation_jog <= ~chb_rotation_jog;
        cyc(10);
        cmp("rot", 32'h1, 32'(chb_lane_rotation));
        chb_powerdown_n <= 1'b1;
        cyc(8);
        cmp("oe_n", 32'h0, 32'(chb_signal_loss_oe_n));
        wr(CSC_CTRL_ADDR, 32'h101, CSC_RESP_OKAY);
        rd(CSC_CTRL_ADDR, 32'h1, CSC_RESP_OKAY);
        cmp("pulse", 32'h1, 32'(n_pulse));
        wr(CSC_CTRL_ADDR, 32'h3, CSC_RESP_OKAY);
        cyc(3);
        cmp("oe_n", 32'h1, 32'(chb_signal_loss_oe_n));
        wr(CSC_CTRL_ADDR, 32'h1, CSC_RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            mgmt_port_addr <= (i == 0) ? {port_strap, CSC_PA_CHB} :
                (i == 1) ? {port_strap, 1'b0} : {~port_strap, CSC_PA_CHB};
            cyc(2);
            cmp("sel", {31'h0, i == 0}, 32'(mgmt_selected));
        end
        aresetn <= 1'b0;
        cyc(5);
        cmp("pin", 32'h0, 32'(pin_level));
        aresetn <= 1'b1;
        rd(CSC_ROT_ADDR, 32'h0, CSC_RESP_OKAY);
        conclude();
    end
endmodule // csc_chb_pins_tb
`default_nettype wire

// [hw/csc_chb_pins.sv]
// Channel B loss indicator, rotation jog, power-down and clock select logic.
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE_01: Indicator high on loss, low when detected.
// RULE_02: Loss at <=75 mV swing if enabled.
// RULE_03: Register routes other functions to indicator.
// RULE_04: Indicator low while device reset held.
// RULE_05: Indicator floats during pin or register power-down.
// RULE_06: One lane rotation per jog edge.
// RULE_07: Power-down pin low powers channel down.
// RULE_08: Host issues datapath reset after power-up.
// RULE_09: Clock zero by register or pin; one register-only.
// RULE_10: Answer management only for PA[0]=1, matching strap.
// RULE_11: Synchronise jog before edge detection.
module csc_chb_pins
    import csc_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Board pins.
    input wire logic chb_rotation_jog,
    input wire logic chb_powerdown_n,
    input wire logic chb_refclk_select,
    input wire logic [3:0] port_strap,
    // Analog detector levels from the receive pair.
    input wire logic chb_swing_low,
    input wire logic chb_swing_high,
    // Management port address of the current transaction.
    input wire logic [4:0] mgmt_port_addr,
    // Indicator pin and datapath controls.
    output logic chb_signal_loss_flag,
    output logic chb_signal_loss_oe_n,
    output logic [1:0] chb_lane_rotation,
    output logic chb_ref_use_one,
    output logic chb_powered_down,
    output logic chb_datapath_reset,
    output logic mgmt_selected,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    csc_sync_if jog_s();
    csc_sync_if pd_s();
    csc_sync_if sel_s();
    csc_sync_if lo_s();
    csc_sync_if hi_s();
    csc_pin_sync u_jog (.aclk(aclk), .aresetn(aresetn), .init_level(1'b0),
        .pin(chb_rotation_jog), .out(jog_s));
    csc_pin_sync u_pd (.aclk(aclk), .aresetn(aresetn), .init_level(1'b1),
        .pin(chb_powerdown_n), .out(pd_s));
    csc_pin_sync u_sel (.aclk(aclk), .aresetn(aresetn), .init_level(1'b0),
        .pin(chb_refclk_select), .out(sel_s));
    csc_pin_sync u_lo (.aclk(aclk), .aresetn(aresetn), .init_level(1'b0),
        .pin(chb_swing_low), .out(lo_s));
    csc_pin_sync u_hi (.aclk(aclk), .aresetn(aresetn), .init_level(1'b0),
        .pin(chb_swing_high), .out(hi_s));

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl;
    logic los;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_ctrl;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_fire;
    logic wr_hit;
    logic dprst_req;
    logic pd_any;
    logic los_en;
    logic next_los;
    logic next_flag;
    logic next_sel;
    csc_obs_type obs_sel;

    assign los_en = ctrl[CSC_CTRL_LOS_EN_BIT];
    assign pd_any = !pd_s.level || ctrl[CSC_CTRL_PD_BIT]; // [RULE_07]
    assign obs_sel = csc_obs_type'(ctrl[CSC_CTRL_OBS_MSB:CSC_CTRL_OBS_LSB]);
    // Between the two thresholds the flag simply holds, a hysteresis band.
    assign next_los = !los_en ? 1'b0 :
                      lo_s.level ? 1'b1 :
                      hi_s.level ? 1'b0 : los; // [RULE_02]
    assign next_flag = (obs_sel == CSC_OBS_LOS) ? los :
                       (obs_sel == CSC_OBS_ROT) ? chb_lane_rotation[0] :
                       (obs_sel == CSC_OBS_REF) ? chb_ref_use_one : pd_any; // [RULE_03]
    // Clock one needs both register bits; a high select pin can only force clock zero.
    assign next_sel = ctrl[CSC_CTRL_REFSW_BIT] && ctrl[CSC_CTRL_REFREG_BIT] &&
                      !sel_s.level; // [RULE_09]

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            los <= 1'b0;
            chb_signal_loss_flag <= 1'b0; // [RULE_04]
            chb_signal_loss_oe_n <= 1'b0;
            chb_powered_down <= 1'b0;
            chb_ref_use_one <= 1'b0;
            mgmt_selected <= 1'b0;
        end else begin
            los <= next_los;
            chb_signal_loss_flag <= next_flag; // [RULE_01]
            chb_signal_loss_oe_n <= pd_any; // [RULE_05]
            chb_powered_down <= pd_any;
            chb_ref_use_one <= next_sel;
            mgmt_selected <= mgmt_port_addr[0] == CSC_PA_CHB &&
                mgmt_port_addr[CSC_PA_MSB:1] == port_strap; // [RULE_10]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chb_lane_rotation <= 2'h0;
        end else if (jog_s.edge_pulse && !pd_any) begin
            chb_lane_rotation <= (chb_lane_rotation == CSC_ROT_LAST) ? 2'h0
                : chb_lane_rotation + 2'h1; // [RULE_06]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = aw_addr == CSC_CTRL_ADDR;
    assign dprst_req = wr_fire && wr_hit && w_strb[1] && w_data[CSC_CTRL_DPRST_BIT];
    always_comb begin
        next_ctrl = ctrl;
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
            end
        end
        // The reset bit is a self-clearing command, never stored.
        next_ctrl[CSC_CTRL_DPRST_BIT] = 1'b0;
    end
    assign rd_hit = s_axi_araddr == CSC_CTRL_ADDR || s_axi_araddr == CSC_STATUS_ADDR ||
                    s_axi_araddr == CSC_PORT_ADDR || s_axi_araddr == CSC_ROT_ADDR;
    assign rd_word = (s_axi_araddr == CSC_CTRL_ADDR) ? ctrl :
                     (s_axi_araddr == CSC_STATUS_ADDR) ?
                         {28'h0, chb_ref_use_one, !pd_s.level, pd_any, los} :
                     (s_axi_araddr == CSC_PORT_ADDR) ? {27'h0, port_strap, CSC_PA_CHB} :
                     (s_axi_araddr == CSC_ROT_ADDR) ? {30'h0, chb_lane_rotation} :
                     CSC_READ_FILL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CSC_RESP_OKAY;
            ctrl <= CSC_CTRL_RESET;
            chb_datapath_reset <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            chb_datapath_reset <= dprst_req;
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
                if (wr_hit) begin
                    ctrl <= next_ctrl;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= CSC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // csc_chb_pins
`default_nettype wire

// [hw/csc_pin_sync.sv]
// Three-stage pin synchroniser with agreement-qualified level and edge pulse.
`timescale 1ns/10ps
`default_nettype none
module csc_pin_sync (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic init_level,
    // Raw pin.
    input wire logic pin,
    // Synchronised result.
    csc_sync_if.source out
);
    logic s1;
    logic s2;
    logic s3;
    logic agree;
    logic next_level;
    assign agree = (s2 == s3);
    assign next_level = agree ? s3 : out.level;
    always_ff @(posedge aclk) begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
    end
    // Reset takes the settled pin level, so a static pin of either idle level gives no edge.
    // The chain needs four reset edges to settle; init_level covers a pin still moving.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out.level <= agree ? s3 : init_level;
            out.edge_pulse <= 1'b0;
        end else begin
            out.level <= next_level;
            out.edge_pulse <= next_level != out.level; // [RULE_11]
        end
    end
endmodule // csc_pin_sync
`default_nettype wire

// [hw/csc_pkg.sv]
// Package with register map, field positions and reset values for the channel B pin logic.
package csc_pkg;
    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] CSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CSC_STATUS_ADDR = 8'h04;
    localparam logic [7:0] CSC_PORT_ADDR = 8'h08;
    localparam logic [7:0] CSC_ROT_ADDR = 8'h0c;
    // Control register field positions.
    localparam int CSC_CTRL_LOS_EN_BIT = 0;
    localparam int CSC_CTRL_PD_BIT = 1;
    localparam int CSC_CTRL_REFSW_BIT = 2;
    localparam int CSC_CTRL_REFREG_BIT = 3;
    localparam int CSC_CTRL_OBS_LSB = 4;
    localparam int CSC_CTRL_OBS_MSB = 5;
    localparam int CSC_CTRL_DPRST_BIT = 8;
    localparam logic [31:0] CSC_CTRL_RESET = 32'h0000_0001;
    // Management port address fields.
    localparam int CSC_PA_MSB = 4;
    localparam logic CSC_PA_CHB = 1'b1;
    // Swing thresholds in millivolts.
    localparam int CSC_LOS_ASSERT_MV = 75;
    localparam int CSC_LOS_DEASSERT_MV = 150;
    localparam logic [1:0] CSC_RESP_OKAY = 2'b00;
    localparam logic [1:0] CSC_RESP_SLVERR = 2'b10;
    localparam logic [31:0] CSC_READ_FILL = 32'h0000_0000;
    // Last lane of the rotation.
    localparam logic [1:0] CSC_ROT_LAST = 2'h3;
    // Observation selections for the loss indicator.
    typedef enum logic [1:0] {
        CSC_OBS_LOS,
        CSC_OBS_ROT,
        CSC_OBS_REF,
        CSC_OBS_PD
    } csc_obs_type;
endpackage : csc_pkg

// [hw/csc_sync_if.sv]
// Interface carrying a synchronised pin level and its edge pulse.
`timescale 1ns/10ps
`default_nettype none
interface csc_sync_if;
    logic level;
    logic edge_pulse;
    modport source (output level, output edge_pulse);
    modport sink (input level, input edge_pulse);
endinterface : csc_sync_if
`default_nettype wire
